// *** lars_ctrl_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module lars_ctrl_model (
	input  wire logic go,
	input  wire logic sys_clk,
	output var logic  start_pulse
);
	// one edge high, low again before the next edge
	always @(posedge sys_clk) begin
		start_pulse <= go;
	end
endmodule : lars_ctrl_model
`default_nettype wire

// *** lars_pixel_mux.sv ***
`timescale 1ns/1ps
`default_nettype none
module lars_pixel_mux #(
	parameter int unsigned N = lars_pkg::SECTION_PIXELS,
	parameter int unsigned W = lars_pkg::PIX_IDX_W
) (
	input  wire logic         sys_clk,
	input  wire logic         rstn,
	input  wire logic [N-1:0] stage,
	output logic [W-1:0]      pixel_index,
	output logic              pixel_valid
);
	// ----------------------------------------
	// one-hot to index, registered
	// ----------------------------------------
	function automatic logic [W-1:0] onehot_idx(input logic [N-1:0] v);
		logic [W-1:0] r;
		r = '0;
		for (int i = 0; i < N; i++) begin
			if (v[i]) begin
				r = W'(i);
			end
		end
		return r;
	endfunction : onehot_idx

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pixel_index <= '0;
		end else begin
			pixel_index <= onehot_idx(stage); // R3
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pixel_valid <= 1'h0;
		end else begin
			pixel_valid <= |stage;
		end
	end
endmodule : lars_pixel_mux
`default_nettype wire

// *** lars_pkg.sv ***
// Contract
// R1: start bit high one edge loads stage zero
// R2: shift register advances start bit each edge
// R3: active stage gates its pixel to output
// R4: stage falling low resets pixel integrator
// R5: bit leaves after last stage, output floats
// R6: controller always supplies the closing clock
// R7: next start no earlier than 130th clock
// R8: start input low before the next edge
// R9: integration time equals start pulse spacing
// R10: output floats whenever no cycle runs
// R11: two independent sections of 64 pixels
// R12: each start input begins its own section
// R13: first section chain pulse drives second start
// R14: second chain pulse cascades or marks end
// R15: chain pulse one clock as bit leaves
package lars_pkg;
	// ----------------------------------------
	// geometry
	// ----------------------------------------
	localparam int unsigned PIXELS_TOTAL = 128;
	localparam int unsigned SECTION_PIXELS = 64;
	localparam int unsigned SECTIONS = 2;
	localparam int unsigned PIX_IDX_W = 6;
	// ----------------------------------------
	// reset values and timing
	// ----------------------------------------
	localparam logic STAGE_RST = 1'h0;
	localparam int unsigned CYCLE_EDGES = PIXELS_TOTAL + 1;
	localparam int unsigned RESTART_EDGE = PIXELS_TOTAL + 2;
endpackage : lars_pkg

// *** lars_section.sv ***
`timescale 1ns/1ps
`default_nettype none
module lars_section #(
	parameter int unsigned N = lars_pkg::SECTION_PIXELS
) (
	input  wire logic         sys_clk,
	input  wire logic         rstn,
	input  wire logic         start_in,
	output logic [N-1:0]      stage,
	output logic [N-1:0]      pix_reset,
	output logic              chain_out,
	output logic              out_enable
);
	// ----------------------------------------
	// shift register
	// ----------------------------------------
	logic [N-1:0] stage_r;
	logic         chain_r;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			stage_r <= {N{lars_pkg::STAGE_RST}};
		end else begin
			stage_r <= {stage_r[N-2:0], start_in}; // R1 R2 R12
		end
	end

	// bit leaving the last stage becomes the one-clock chain pulse
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			chain_r <= 1'h0;
		end else begin
			chain_r <= stage_r[N-1]; // R15 R5
		end
	end

	// integrator reset pulses on the edge a stage drops back to zero
	logic [N-1:0] prev_r;
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			prev_r <= {N{1'h0}};
		end else begin
			prev_r <= stage_r;
		end
	end

	assign pix_reset  = prev_r & ~stage_r; // R4 R9
	assign stage      = stage_r; // R3
	assign chain_out  = chain_r;
	assign out_enable = |stage_r; // R10

	property p_reset_follows;
		@(posedge sys_clk) disable iff (!rstn)
		stage_r[0] |=> (!stage_r[0] |-> pix_reset[0]);
	endproperty
	a_reset_follows : assert property (p_reset_follows) else $error("pixel reset missing after stage fall"); // R4
endmodule : lars_section
`default_nettype wire

// *** lars_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// pixel_voltage_out_* are modelled digitally: a select index and a drive enable;
// enable low means the analog pin floats
module lars_top #(
	parameter int unsigned N = lars_pkg::SECTION_PIXELS,
	parameter int unsigned W = lars_pkg::PIX_IDX_W
) (
	input  wire logic         sys_clk,
	input  wire logic         rstn,
	input  wire logic         start_pulse_in_first,
	input  wire logic         start_pulse_in_second,
	output logic              chain_pulse_out_first,
	output logic              chain_pulse_out_second,
	output logic [W-1:0]      pixel_voltage_out_first,
	output logic              pixel_voltage_out_first_oe,
	output logic [W-1:0]      pixel_voltage_out_second,
	output logic              pixel_voltage_out_second_oe,
	output logic [N-1:0]      integ_reset_first,
	output logic [N-1:0]      integ_reset_second
);
	// ----------------------------------------
	// two independent sections
	// ----------------------------------------
	logic [N-1:0] stage_a;
	logic [N-1:0] stage_b;
	logic         oe_a;
	logic         oe_b;

	lars_section #(.N(N)) u_sec_first ( // R11 R12
		.sys_clk   (sys_clk),
		.rstn      (rstn),
		.start_in  (start_pulse_in_first),
		.stage     (stage_a),
		.pix_reset (integ_reset_first),
		.chain_out (chain_pulse_out_first), // R13
		.out_enable(oe_a)
	);

	lars_section #(.N(N)) u_sec_second (
		.sys_clk   (sys_clk),
		.rstn      (rstn),
		.start_in  (start_pulse_in_second),
		.stage     (stage_b),
		.pix_reset (integ_reset_second),
		.chain_out (chain_pulse_out_second), // R14
		.out_enable(oe_b)
	);

	// ----------------------------------------
	// output selection, registered data
	// ----------------------------------------
	lars_pixel_mux #(.N(N), .W(W)) u_mux_first (
		.sys_clk    (sys_clk),
		.rstn       (rstn),
		.stage      (stage_a),
		.pixel_index(pixel_voltage_out_first),
		.pixel_valid(pixel_voltage_out_first_oe) // R10
	);

	lars_pixel_mux #(.N(N), .W(W)) u_mux_second (
		.sys_clk    (sys_clk),
		.rstn       (rstn),
		.stage      (stage_b),
		.pixel_index(pixel_voltage_out_second),
		.pixel_valid(pixel_voltage_out_second_oe)
	);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_start_a;
		start_pulse_in_first ##1 !start_pulse_in_first;
	endsequence

	property p_load;
		@(posedge sys_clk) disable iff (!rstn)
		start_pulse_in_first |=> stage_a[0];
	endproperty
	a_load : assert property (p_load) else $error("start bit not loaded"); // R1

	property p_shift;
		@(posedge sys_clk) disable iff (!rstn)
		stage_a[0] |=> stage_a[1] ##1 stage_a[2];
	endproperty
	a_shift : assert property (p_shift) else $error("start bit did not advance"); // R2

	property p_chain;
		@(posedge sys_clk) disable iff (!rstn)
		s_start_a |-> ##64 chain_pulse_out_first ##1 !chain_pulse_out_first;
	endproperty
	a_chain : assert property (p_chain) else $error("chain pulse wrong time"); // R15 R13

	property p_chain_b;
		@(posedge sys_clk) disable iff (!rstn)
		stage_b[N-1] |=> chain_pulse_out_second;
	endproperty
	a_chain_b : assert property (p_chain_b) else $error("second chain pulse missing"); // R14

	property p_float;
		@(posedge sys_clk) disable iff (!rstn)
		(stage_a == '0) |=> !pixel_voltage_out_first_oe;
	endproperty
	a_float : assert property (p_float) else $error("output driven while idle"); // R10 R5

	property p_present;
		@(posedge sys_clk) disable iff (!rstn)
		stage_a[5] |=> pixel_voltage_out_first_oe && pixel_voltage_out_first == 6'h05;
	endproperty
	a_present : assert property (p_present) else $error("wrong pixel presented"); // R3

	property p_intreset;
		@(posedge sys_clk) disable iff (!rstn)
		$fell(stage_b[3]) |-> integ_reset_second[3];
	endproperty
	a_intreset : assert property (p_intreset) else $error("integrator reset missing"); // R4

	property p_indep;
		@(posedge sys_clk) disable iff (!rstn)
		start_pulse_in_second |=> stage_b[0];
	endproperty
	a_indep : assert property (p_indep) else $error("second section did not start"); // R12 R11

	// ----------------------------------------
	// run-length helpers
	// ----------------------------------------
	// a 64-long repetition would be too heavy to unroll, so drive runs are counted instead
	logic [W:0] run_a_r;
	logic [W:0] run_b_r;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			run_a_r <= '0;
		end else if (pixel_voltage_out_first_oe) begin
			run_a_r <= (W+1)'(run_a_r + 1'h1);
		end else begin
			run_a_r <= '0;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			run_b_r <= '0;
		end else if (pixel_voltage_out_second_oe) begin
			run_b_r <= (W+1)'(run_b_r + 1'h1);
		end else begin
			run_b_r <= '0;
		end
	end

	// ----------------------------------------
	// further checks, both sections
	// ----------------------------------------
	sequence s_start_b;
		start_pulse_in_second ##1 !start_pulse_in_second;
	endsequence

	sequence s_leave_a;
		stage_a[N-1] ##1 (stage_a == '0);
	endsequence

	sequence s_leave_b;
		stage_b[N-1] ##1 (stage_b == '0);
	endsequence

	property p_onehot_a;
		@(posedge sys_clk) disable iff (!rstn)
		$onehot0(stage_a);
	endproperty
	a_onehot_a : assert property (p_onehot_a) else $error("more than one start bit in first section"); // R2

	property p_onehot_b;
		@(posedge sys_clk) disable iff (!rstn)
		$onehot0(stage_b);
	endproperty
	a_onehot_b : assert property (p_onehot_b) else $error("more than one start bit in second section"); // R2 R11

	property p_shift_b;
		@(posedge sys_clk) disable iff (!rstn)
		stage_b[0] |=> stage_b[1] ##1 stage_b[2];
	endproperty
	a_shift_b : assert property (p_shift_b) else $error("second start bit did not advance"); // R2

	property p_chain_one_a;
		@(posedge sys_clk) disable iff (!rstn)
		chain_pulse_out_first |=> !chain_pulse_out_first;
	endproperty
	a_chain_one_a : assert property (p_chain_one_a) else $error("first chain pulse too long"); // R15

	property p_chain_one_b;
		@(posedge sys_clk) disable iff (!rstn)
		chain_pulse_out_second |=> !chain_pulse_out_second;
	endproperty
	a_chain_one_b : assert property (p_chain_one_b) else $error("second chain pulse too long"); // R15

	property p_chain_src_a;
		@(posedge sys_clk) disable iff (!rstn)
		chain_pulse_out_first |-> $past(stage_a[N-1]);
	endproperty
	a_chain_src_a : assert property (p_chain_src_a) else $error("first chain pulse without last stage"); // R15 R5

	property p_chain_walk_b;
		@(posedge sys_clk) disable iff (!rstn)
		s_start_b |-> ##64 chain_pulse_out_second ##1 !chain_pulse_out_second;
	endproperty
	a_chain_walk_b : assert property (p_chain_walk_b) else $error("second chain pulse wrong time"); // R14 R15

	property p_float_b;
		@(posedge sys_clk) disable iff (!rstn)
		(stage_b == '0) |=> !pixel_voltage_out_second_oe;
	endproperty
	a_float_b : assert property (p_float_b) else $error("second output driven while idle"); // R10

	property p_present_b;
		@(posedge sys_clk) disable iff (!rstn)
		stage_b[5] |=> pixel_voltage_out_second_oe && pixel_voltage_out_second == 6'h05;
	endproperty
	a_present_b : assert property (p_present_b) else $error("wrong second pixel presented"); // R3

	property p_first_pix_a;
		@(posedge sys_clk) disable iff (!rstn)
		stage_a[0] |=> pixel_voltage_out_first_oe && pixel_voltage_out_first == '0;
	endproperty
	a_first_pix_a : assert property (p_first_pix_a) else $error("first pixel of first section wrong"); // R3

	property p_first_pix_b;
		@(posedge sys_clk) disable iff (!rstn)
		stage_b[0] |=> pixel_voltage_out_second_oe && pixel_voltage_out_second == '0;
	endproperty
	a_first_pix_b : assert property (p_first_pix_b) else $error("first pixel of second section wrong"); // R3

	property p_last_pix_a;
		@(posedge sys_clk) disable iff (!rstn)
		stage_a[N-1] |=> pixel_voltage_out_first_oe && pixel_voltage_out_first == W'(N-1);
	endproperty
	a_last_pix_a : assert property (p_last_pix_a) else $error("last pixel of first section wrong"); // R3

	property p_last_pix_b;
		@(posedge sys_clk) disable iff (!rstn)
		stage_b[N-1] |=> pixel_voltage_out_second_oe && pixel_voltage_out_second == W'(N-1);
	endproperty
	a_last_pix_b : assert property (p_last_pix_b) else $error("last pixel of second section wrong"); // R3

	property p_end_a;
		@(posedge sys_clk) disable iff (!rstn)
		s_leave_a |=> !pixel_voltage_out_first_oe;
	endproperty
	a_end_a : assert property (p_end_a) else $error("first output not floated at cycle end"); // R5

	property p_end_b;
		@(posedge sys_clk) disable iff (!rstn)
		s_leave_b |=> !pixel_voltage_out_second_oe;
	endproperty
	a_end_b : assert property (p_end_b) else $error("second output not floated at cycle end"); // R5

	property p_oe_reg_a;
		@(posedge sys_clk) disable iff (!rstn)
		oe_a |=> pixel_voltage_out_first_oe;
	endproperty
	a_oe_reg_a : assert property (p_oe_reg_a) else $error("first output not driven while active"); // R10

	property p_oe_idle_a;
		@(posedge sys_clk) disable iff (!rstn)
		!oe_a |=> !pixel_voltage_out_first_oe;
	endproperty
	a_oe_idle_a : assert property (p_oe_idle_a) else $error("first output driven without active stage"); // R10

	property p_oe_reg_b;
		@(posedge sys_clk) disable iff (!rstn)
		oe_b |=> pixel_voltage_out_second_oe;
	endproperty
	a_oe_reg_b : assert property (p_oe_reg_b) else $error("second output not driven while active"); // R10

	property p_oe_idle_b;
		@(posedge sys_clk) disable iff (!rstn)
		!oe_b |=> !pixel_voltage_out_second_oe;
	endproperty
	a_oe_idle_b : assert property (p_oe_idle_b) else $error("second output driven without active stage"); // R10

	property p_step_a;
		@(posedge sys_clk) disable iff (!rstn)
		(pixel_voltage_out_first_oe && pixel_voltage_out_first != W'(N-1)) |=>
			pixel_voltage_out_first_oe && pixel_voltage_out_first == W'($past(pixel_voltage_out_first) + 1'h1);
	endproperty
	a_step_a : assert property (p_step_a) else $error("first section pixels out of order"); // R3

	property p_step_b;
		@(posedge sys_clk) disable iff (!rstn)
		(pixel_voltage_out_second_oe && pixel_voltage_out_second != W'(N-1)) |=>
			pixel_voltage_out_second_oe && pixel_voltage_out_second == W'($past(pixel_voltage_out_second) + 1'h1);
	endproperty
	a_step_b : assert property (p_step_b) else $error("second section pixels out of order"); // R3

	property p_intreset_a;
		@(posedge sys_clk) disable iff (!rstn)
		$fell(stage_a[0]) |-> integ_reset_first[0];
	endproperty
	a_intreset_a : assert property (p_intreset_a) else $error("first section integrator reset missing"); // R4

	property p_intreset_src_a;
		@(posedge sys_clk) disable iff (!rstn)
		integ_reset_first[3] |-> $past(stage_a[3]) && !stage_a[3];
	endproperty
	a_intreset_src_a : assert property (p_intreset_src_a) else $error("integrator reset without stage fall"); // R4

	property p_intreset_one_b;
		@(posedge sys_clk) disable iff (!rstn)
		integ_reset_second[3] |=> !integ_reset_second[3];
	endproperty
	a_intreset_one_b : assert property (p_intreset_one_b) else $error("integrator reset too long"); // R4

	property p_len_a;
		@(posedge sys_clk) disable iff (!rstn)
		$fell(pixel_voltage_out_first_oe) |-> run_a_r == (W+1)'(N);
	endproperty
	a_len_a : assert property (p_len_a) else $error("first output drive length wrong"); // R3 R10

	property p_len_b;
		@(posedge sys_clk) disable iff (!rstn)
		$fell(pixel_voltage_out_second_oe) |-> run_b_r == (W+1)'(N);
	endproperty
	a_len_b : assert property (p_len_b) else $error("second output drive length wrong"); // R3 R10

	property p_len_max_a;
		@(posedge sys_clk) disable iff (!rstn)
		run_a_r <= (W+1)'(N);
	endproperty
	a_len_max_a : assert property (p_len_max_a) else $error("first output driven too long"); // R10

	property p_len_max_b;
		@(posedge sys_clk) disable iff (!rstn)
		run_b_r <= (W+1)'(N);
	endproperty
	a_len_max_b : assert property (p_len_max_b) else $error("second output driven too long"); // R10
endmodule : lars_top
`default_nettype wire

// *** linear_array_readout_sequencer_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module linear_array_readout_sequencer_tb;
	logic sys_clk = 1'h0, rstn = 1'h0, go1 = 1'h0, go2 = 1'h0, chain_mode = 1'h1;
	logic s1, s2, c1, c2, oe1, oe2;
	logic [5:0] ix1, ix2;
	logic [63:0] ir1, ir2;
	int t1 = -1, t2 = -1, n1 = 0, n2 = 0, nr1 = 0, nr2 = 0, n_mismatch = 0, cmp_count = 0;
	wire logic st2 = chain_mode ? c1 : s2;
	always #5 sys_clk = ~sys_clk;
	lars_ctrl_model ctl1_u (.go(go1), .sys_clk(sys_clk), .start_pulse(s1));
	lars_ctrl_model ctl2_u (.go(go2), .sys_clk(sys_clk), .start_pulse(s2));
	lars_top dut_u (.sys_clk(sys_clk), .rstn(rstn), .start_pulse_in_first(s1), .start_pulse_in_second(st2),
		.chain_pulse_out_first(c1), .chain_pulse_out_second(c2), .pixel_voltage_out_first(ix1),
		.pixel_voltage_out_first_oe(oe1), .pixel_voltage_out_second(ix2), .pixel_voltage_out_second_oe(oe2),
		.integ_reset_first(ir1), .integ_reset_second(ir2));
	// ----------------------------------------
	// reference model: cycles since capture
	// ----------------------------------------
	always @(posedge sys_clk) begin
		logic b2;
		b2 = chain_mode ? (t1 == 65) : s2;
		n1 += (s1 === 1'h1);
		n2 += b2;
		t1 <= (s1 === 1'h1) ? 1 : (t1 >= 0 && t1 < 70) ? t1 + 1 : -1;
		t2 <= b2 ? 1 : (t2 >= 0 && t2 < 70) ? t2 + 1 : -1;
	end
	task automatic chk_flag(input logic e, input logic g);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %0t flag exp %h got %h", $time, e, g);
		end
	endtask : chk_flag
	task automatic chk_val(input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %0t value exp %h got %h", $time, e, g);
		end
	endtask : chk_val
	always @(negedge sys_clk) if (rstn) begin
		chk_flag(t1 >= 2 && t1 <= 65, oe1);
		if (t1 >= 2 && t1 <= 65) chk_val(t1 - 2, ix1);
		chk_flag(t1 == 65, c1);
		chk_flag(t2 >= 2 && t2 <= 65, oe2);
		if (t2 >= 2 && t2 <= 65) chk_val(t2 - 2, ix2);
		chk_flag(t2 == 65, c2);
		nr1 += $countones(ir1);
		nr2 += $countones(ir2);
	end
	task automatic pulse(input int sec);
		if (sec == 1) go1 <= 1'h1;
		else go2 <= 1'h1;
		@(posedge sys_clk);
		if (sec == 1) go1 <= 1'h0;
		else go2 <= 1'h0;
	endtask : pulse
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : print_verdict
	initial begin
		int r;
		r = $urandom(32'hc9f8acf6);
		repeat (4) @(posedge sys_clk);
		rstn <= 1'h1;
		// chained readout, first gap at the minimum restart spacing
		for (int i = 0; i < 3; i++) begin
			pulse(1);
			repeat ((i == 0 ? 128 : 128 + $urandom % 32)) @(posedge sys_clk);
		end
		repeat (140) @(posedge sys_clk);
		$display("chained test done");
		chain_mode <= 1'h0;
		// independent sections with random relative offset
		for (int i = 0; i < 4; i++) begin
			pulse(1);
			repeat ($urandom % 70) @(posedge sys_clk);
			pulse(2);
			repeat (140) @(posedge sys_clk);
		end
		$display("independent test done");
		chk_val(64 * n1, nr1);
		chk_val(64 * n2, nr2);
		print_verdict();
	end
	initial begin
		#(5000 * 10);
		n_mismatch++;
		print_verdict();
	end
endmodule : linear_array_readout_sequencer_tb
`default_nettype wire
